/* File: dv/jdr_access_sva.sv */
// Port-level checks for the debug register access block
`timescale 1ns/1ps
module jdr_access_sva
    import jdr_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        rdy_n_o,
    input wire logic        sb_req_o,
    input wire logic        sb_we_o,
    input wire logic [31:0] sb_addr_o,
    input wire logic [31:0] sb_wdata_o,
    input wire logic [1:0]  sb_size_o,
    input wire logic        sb_ack_i,
    input wire logic [1:0]  sb_resp_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic       good_ack;
    logic       err_ack;
    logic [7:0] low_q;
    logic [7:0] low_d;

    assign good_ack = sb_req_o && sb_ack_i && sb_resp_i != SB_RESP_ERR;
    assign err_ack  = sb_req_o && sb_ack_i && sb_resp_i == SB_RESP_ERR;

    // Length of the current ready pulse
    always_comb low_d = rdy_n_o ? 8'h00 : low_q + 8'h01;
    always_ff @(posedge clk_i) low_q <= rst_i ? 8'h00 : low_d;

    a_rdy_after_good: assert property (good_ack |=> $fell(rdy_n_o))
        else $error("ready did not fall after a good completion");
    a_rdy_has_cause: assert property ($fell(rdy_n_o) |-> $past(good_ack))
        else $error("ready fell without a good completion");
    a_rdy_pulse_len: assert property ($rose(rdy_n_o) |-> low_q == 8'(RDY_LOW_CYC))
        else $error("ready low time wrong");
    a_err_no_ready: assert property (err_ack |=> (rdy_n_o && !sb_req_o) [*8])
        else $error("error answer gave ready or a retry");
    a_req_held: assert property (sb_req_o && !sb_ack_i |=>
                                 sb_req_o && $stable({sb_we_o, sb_addr_o, sb_wdata_o, sb_size_o}))
        else $error("bus request changed before its answer");
    a_req_released: assert property (sb_req_o && sb_ack_i |=> !sb_req_o)
        else $error("bus request not released after answer");
    a_req_when_idle: assert property ($rose(sb_req_o) |-> rdy_n_o)
        else $error("bus request during ready pulse");
    a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("wishbone ack late");
    a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack longer than one cycle");
    a_wb_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("wishbone ack without request");
endmodule : jdr_access_sva

bind jdr_access jdr_access_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .rdy_n_o(rdy_n_o), .sb_req_o(sb_req_o), .sb_we_o(sb_we_o),
    .sb_addr_o(sb_addr_o), .sb_wdata_o(sb_wdata_o), .sb_size_o(sb_size_o), .sb_ack_i(sb_ack_i),
    .sb_resp_i(sb_resp_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

/* File: dv/jdr_tool_model.sv */
// Test port driver standing in for the development tool
`timescale 1ns/1ps
module jdr_tool_model (
    output logic     tck_o,
    output logic     tms_o,
    output logic     tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    logic last_bit;

    initial begin
        tck_o    = 1'b0;
        tms_o    = 1'b1;
        tdi_o    = 1'b0;
        last_bit = 1'b0;
    end

    // One 64 ns test clock; a released data line reads as its inverse
    task automatic tclk(input logic ms, input logic di, output logic dout);
        tms_o <= ms;
        tdi_o <= di;
        #32;
        dout = tdo_oe_i ? tdo_i : ~last_bit;
        last_bit = dout;
        tck_o <= 1'b1;
        #32;
        tck_o <= 1'b0;
    endtask : tclk

    task automatic to_idle();
        logic b;
        repeat (5) tclk(1'b1, 1'b0, b);
        tclk(1'b0, 1'b0, b);
    endtask : to_idle

    // From select to update, n bits low first
    task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = 32'h0;
        tclk(1'b0, ~tdi_o, b);
        tclk(1'b0, ~tdi_o, b);
        for (int i = 0; i < n; i++) begin
            tclk(i == n - 1, din[i], b);
            dout[i] = b;
        end
        tclk(1'b1, ~tdi_o, b);
    endtask : scan

    // Command scan then data scan, 13 and 37 clocks idle to idle
    task automatic access(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                          output logic [31:0] rd, output logic [6:0] cmd_prev);
        logic        b;
        logic [31:0] c;
        tclk(1'b0, ~tdi_o, b);
        tclk(1'b1, ~tdi_o, b);
        scan(7, {25'h0, idx, wr}, c);
        cmd_prev = c[6:0];
        tclk(1'b1, ~tdi_o, b);
        scan(32, wd, rd);
        tclk(1'b0, ~tdi_o, b);
        tclk(1'b0, ~tdi_o, b);
    endtask : access
endmodule : jdr_tool_model

/* File: dv/tb_top.sv */
// Self-checking bench for the debug register access block
`timescale 1ns/1ps
module tb_top;
    import jdr_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        tck, tms, tdi, tdo, tdo_oe, rdy_n, rdy_q = 1'b1;
    logic        sb_req, sb_we, sb_ack = 1'b0, err_mode = 1'b0;
    logic [1:0]  sb_size, sb_resp = 2'b00, size_seen = 2'b00;
    logic [31:0] sb_addr, sb_wdata, sb_rdata = 32'h0;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, irq;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rd, q;
    logic [6:0]  cmd;
    logic [31:0] acc_addr [8];
    logic [31:0] acc_data [8];
    int          lat = 0, wait_n = 0, n_acc = 0, falls = 0, base, fall0;
    int          fail_count = 0, samples_checked = 0;

    always #2.5 clk_i = ~clk_i;

    jdr_access dut (
        .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .rdy_n_o(rdy_n),
        .sb_req_o(sb_req), .sb_we_o(sb_we), .sb_addr_o(sb_addr), .sb_wdata_o(sb_wdata),
        .sb_size_o(sb_size), .sb_ack_i(sb_ack), .sb_resp_i(sb_resp), .sb_rdata_i(sb_rdata),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq)
    );
    jdr_tool_model u_tool (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

    function automatic logic [31:0] pat(input logic [31:0] a);
        return a ^ 32'h3c3c_0f0f;
    endfunction : pat

    // System bus slave: set latency, optional error answer, data changes outside acks
    always @(posedge clk_i) begin
        sb_ack   <= 1'b0;
        sb_rdata <= ~sb_rdata;
        sb_resp  <= {1'b0, err_mode};
        if (sb_req && !sb_ack) begin
            if (wait_n >= lat) begin
                sb_ack               <= 1'b1;
                sb_rdata             <= pat(sb_addr);
                acc_addr[n_acc % 8]  <= sb_addr;
                acc_data[n_acc % 8]  <= sb_wdata;
                size_seen            <= sb_size;
                n_acc                <= n_acc + 1;
                wait_n               <= 0;
            end else begin
                wait_n <= wait_n + 1;
            end
        end
    end

    always @(posedge clk_i) begin
        rdy_q <= rdy_n;
        if (rdy_q === 1'b1 && rdy_n === 1'b0) begin
            falls <= falls + 1;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= a;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        check("wb ack", 32'h1, 32'(wb_ack));
        r = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic jr(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        u_tool.access(wr, idx, wd, rd, cmd);
    endtask : jr

    task automatic wait_rdy(input int want);
        for (int i = 0; i < 2000 && falls < want; i++) begin
            @(posedge clk_i);
        end
        check("ready falls", 32'(want), 32'(falls));
    endtask : wait_rdy

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        $display("mismatch watchdog expected done seen timeout");
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        u_tool.to_idle();
        wb(1'b0, WB_CTRL, 32'h0, q);
        check("ctrl reset", 32'h1, q);
        wb(1'b0, 8'h14, 32'h0, q);
        check("unmapped", 32'h0, q);
        wb(1'b1, WB_IRQ_EN, 32'h3, q);
        // Register write, reads that must not write, command capture
        jr(1'b1, IDX_ACC_ADDR, 32'h1000_0100);
        for (int i = 0; i < 2; i++) begin
            jr(1'b0, IDX_ACC_ADDR, 32'hffff_ffff);
            check("addr reg", 32'h1000_0100, rd);
            check("cmd capture", 32'({IDX_ACC_ADDR, ~i[0]}), 32'(cmd));
        end
        // Single read on a slow bus, then three-word block read on a prompt one
        for (int s = 0; s < 2; s++) begin
            lat <= s ? 0 : 5;
            base = n_acc;
            fall0 = falls;
            jr(1'b1, IDX_ACC_ADDR, 32'h2000_0000 + s * 256);
            jr(1'b1, IDX_ACC_CS, s ? 32'h8080_0300 : 32'h8080_0100);
            for (int k = 0; k <= 2 * s; k++) begin
                wait_rdy(fall0 + k + 1);
                jr(1'b0, IDX_ACC_DATA, 32'h0);
                check("read word", pat(32'h2000_0000 + s * 256 + 4 * k), rd);
            end
            jr(1'b0, IDX_ACC_CS, 32'h0);
            check("cs after read", s ? 32'h0080_0301 : 32'h0080_0101, rd & 32'h7fff_ff03);
            check("bus reads", 32'(2 * s + 1), 32'(n_acc - base));
            jr(1'b0, IDX_ACC_ADDR, 32'h0);
            check("addr kept", 32'h2000_0000 + s * 256, rd);
        end
        // Two half-word block write
        lat <= 3;
        base = n_acc;
        fall0 = falls;
        jr(1'b1, IDX_ACC_CS, 32'h8240_0200);
        jr(1'b1, IDX_ACC_ADDR, 32'h3000_0002);
        for (int k = 0; k < 2; k++) begin
            jr(1'b1, IDX_ACC_DATA, 32'h5500_00a0 + k);
            wait_rdy(fall0 + k + 1);
            check("write addr", 32'h3000_0002 + 2 * k, acc_addr[(base + k) % 8]);
            check("write data", 32'h5500_00a0 + k, acc_data[(base + k) % 8]);
        end
        jr(1'b0, IDX_ACC_CS, 32'h0);
        check("cs after write", 32'h0240_0200, rd & 32'h7fff_ff03);
        check("write size", 32'h1, 32'(size_seen));
        wb(1'b0, WB_STATE, 32'h0, q);
        check("state idle", 32'h0004_0000, q);
        // Port switched off: scans must not reach the registers
        wb(1'b1, WB_CTRL, 32'h0, q);
        jr(1'b1, IDX_ACC_ADDR, 32'h0bad_0000);
        wb(1'b1, WB_CTRL, 32'h1, q);
        u_tool.to_idle();
        jr(1'b0, IDX_ACC_ADDR, 32'h0);
        check("addr while off", 32'h3000_0002, rd);
        // Error answer ends the access without ready
        err_mode <= 1'b1;
        fall0 = falls;
        jr(1'b1, IDX_ACC_CS, 32'h8080_0100);
        repeat (200) @(posedge clk_i);
        check("ready after error", 32'(fall0), 32'(falls));
        jr(1'b0, IDX_ACC_CS, 32'h0);
        check("cs after error", 32'h0080_0102, rd & 32'hffff_ff03);
        // Interrupt status, mask and clear
        wb(1'b0, WB_IRQ_STS, 32'h0, q);
        check("irq status", 32'h7, q);
        wb(1'b1, WB_IRQ_EN, 32'h0, q);
        @(posedge clk_i);
        check("irq masked", 32'h0, 32'(irq));
        wb(1'b1, WB_IRQ_EN, 32'h2, q);
        @(posedge clk_i);
        check("irq error", 32'h1, 32'(irq));
        wb(1'b1, WB_IRQ_CLR, 32'h7, q);
        @(posedge clk_i);
        check("irq cleared", 32'h0, 32'(irq));
        stop_test();
    end
endmodule : tb_top

/* File: hw/jdr_access.sv */
// Debug register access over the test port, with system bus master and Wishbone control
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Capture-DR in select state loads command
// RQ2: Command scan shifts seven bits, direction first
// RQ3: Update-DR latches shifter into command register
// RQ4: Second scan captures selected register value
// RQ5: Thirty-two bit data scan, LSB first
// RQ6: Update-DR writes register only for writes
// RQ7: After data update return to select state
// RQ8: Tool spends 13 and 37 clocks
// RQ9: Read: address first, then control/status start
// RQ10: Tool waits ready fall, then reads data
// RQ11: Block read repeats while count above zero
// RQ12: Write: control/status first, then address
// RQ13: Write data scan starts bus write
// RQ14: Indices 9, 7, 0xA select access registers
// RQ15: Good completion pulses ready, updates data-valid
// RQ16: Internal address and count advance, programmed unchanged
// RQ17: Error response clears start, sets error
module jdr_access
    import jdr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Test port pins
    input  wire logic        tck_i,
    input  wire logic        tms_i,
    input  wire logic        tdi_i,
    output logic             tdo_o,
    output logic             tdo_oe_o,
    output logic             rdy_n_o,
    // System bus master
    output logic             sb_req_o,
    output logic             sb_we_o,
    output logic [31:0]      sb_addr_o,
    output logic [31:0]      sb_wdata_o,
    output logic [1:0]       sb_size_o,
    input  wire logic        sb_ack_i,
    input  wire logic [1:0]  sb_resp_i,
    input  wire logic [31:0] sb_rdata_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o
);
    localparam int unsigned RDY_W = $clog2(RDY_LOW_CYC + 1);
    localparam logic [RDY_W-1:0] RDY_LOAD = RDY_W'(RDY_LOW_CYC);

    typedef struct packed {
        jdr_mode_t        mode;
        logic [6:0]       cmd;
        logic [31:0]      sh;
        logic [31:0]      acc_addr;
        logic [31:0]      acc_cs;
        logic [31:0]      acc_data;
        logic [31:0]      cur_addr;
        logic [CNT_W-1:0] left;
        jdr_bus_t         bus;
        logic             bus_we;
        logic             tck_d;
        logic             tdo;
        logic             tdo_oe;
        logic [RDY_W-1:0] rdy_cnt;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_en;
        logic             port_en;
        logic             wb_ack;
        logic [31:0]      wb_dat;
    } jdr_acc_st_t;

    jdr_acc_st_t st_q;
    jdr_acc_st_t st_d;

    logic [2:0] pins_s;
    jdr_tap_t   tap;
    logic       tck_s;
    logic       tck_rise;
    logic       tck_fall;

    jdr_sync #(
        .W (3)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({tck_i, tms_i, tdi_i}),
        .q_o   (pins_s)
    );

    assign tck_s    = pins_s[2];
    assign tck_rise = tck_s & ~st_q.tck_d;
    assign tck_fall = ~tck_s & st_q.tck_d;

    jdr_tap u_tap (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .hold_i     (~st_q.port_en),
        .tck_rise_i (tck_rise),
        .tms_i      (pins_s[1]),
        .state_o    (tap)
    );

    function automatic logic [31:0] sel_val(input logic [5:0] idx, input jdr_acc_st_t s);
        logic [31:0] v;
        v = '0;
        if (idx == IDX_ACC_ADDR) begin // [RQ14]
            v = s.acc_addr;
        end else if (idx == IDX_ACC_CS) begin
            v = s.acc_cs;
        end else if (idx == IDX_ACC_DATA) begin
            v = s.acc_data;
        end
        return v;
    endfunction : sel_val

    function automatic logic [31:0] step_of(input logic [2:0] sz);
        logic [31:0] v;
        v = 32'h0000_0001;
        if (sz[1:0] == 2'b01) begin
            v = 32'h0000_0002;
        end else if (sz[1:0] == 2'b10) begin
            v = 32'h0000_0004;
        end
        return v;
    endfunction : step_of

    logic [5:0]       cmd_idx;
    logic             cmd_wr;
    logic             upd_data;
    logic [IRQ_W-1:0] ev;
    logic             wb_req;
    logic [CNT_W-1:0] cnt_prog;

    assign cmd_idx  = st_q.cmd[6:1];
    assign cmd_wr   = st_q.cmd[0];
    assign upd_data = tck_rise & (tap == TAP_UPDR) & (st_q.mode == MODE_DATA);
    assign wb_req   = wb_cyc_i & wb_stb_i & ~st_q.wb_ack;
    assign cnt_prog = st_q.sh[CS_CNT_LSB +: CNT_W];

    always_comb begin
        st_d       = st_q;
        ev         = '0;
        st_d.tck_d = tck_s;
        st_d.wb_ack = 1'b0;

        // Test clock rising edge: capture, shift, update
        if (tck_rise) begin
            if (tap == TAP_TLR) begin
                st_d.mode = MODE_CMD;
            end
            if (tap == TAP_CAPDR) begin
                if (st_q.mode == MODE_CMD) begin
                    st_d.sh = {25'h0, st_q.cmd}; // [RQ1]
                end else begin
                    st_d.sh = sel_val(cmd_idx, st_q); // [RQ4]
                end
            end
            if (tap == TAP_SHDR) begin
                if (st_q.mode == MODE_CMD) begin
                    st_d.sh = {25'h0, pins_s[0], st_q.sh[6:1]}; // [RQ2]
                end else begin
                    st_d.sh = {pins_s[0], st_q.sh[31:1]}; // [RQ5]
                end
            end
            if (tap == TAP_UPDR) begin
                if (st_q.mode == MODE_CMD) begin
                    st_d.cmd  = st_q.sh[6:0]; // [RQ3]
                    st_d.mode = MODE_DATA;
                    ev[IRQ_CMD] = 1'b1;
                end else begin
                    st_d.mode = MODE_CMD; // [RQ7]
                end
            end
        end

        // Data scan update: register writes and access starts
        if (upd_data && cmd_wr) begin // [RQ6]
            if (cmd_idx == IDX_ACC_ADDR) begin
                st_d.acc_addr = st_q.sh;
                st_d.cur_addr = st_q.sh;
            end else if (cmd_idx == IDX_ACC_CS) begin
                st_d.acc_cs = (st_q.sh & CS_WR_MASK) | {30'h0, 1'b0, st_q.acc_cs[CS_DV_POS]};
                st_d.cur_addr = st_q.acc_addr;
                st_d.left = (cnt_prog == '0) ? CNT_W'(1) : cnt_prog;
                if (st_q.sh[CS_START_POS] && !st_q.sh[CS_RW_POS] && st_q.bus == BUS_IDLE) begin
                    st_d.bus    = BUS_ACT;
                    st_d.bus_we = 1'b0;
                end
            end else if (cmd_idx == IDX_ACC_DATA) begin
                st_d.acc_data = st_q.sh;
                if (st_q.acc_cs[CS_START_POS] && st_q.acc_cs[CS_RW_POS] &&
                    st_q.left != '0 && st_q.bus == BUS_IDLE) begin
                    st_d.bus    = BUS_ACT; // [RQ13]
                    st_d.bus_we = 1'b1;
                end
            end
        end

        // Next word of a block read once the previous word was scanned out
        if (upd_data && !cmd_wr && cmd_idx == IDX_ACC_DATA && st_q.bus == BUS_IDLE &&
            st_q.acc_cs[CS_START_POS] && !st_q.acc_cs[CS_RW_POS] && st_q.left != '0) begin
            st_d.bus    = BUS_ACT; // [RQ11]
            st_d.bus_we = 1'b0;
        end

        // Ready pulse countdown
        if (st_q.rdy_cnt != '0) begin
            st_d.rdy_cnt = st_q.rdy_cnt - RDY_W'(1);
        end

        // System bus completion
        if (st_q.bus == BUS_ACT && sb_ack_i) begin
            st_d.bus = BUS_IDLE;
            if (sb_resp_i == SB_RESP_ERR) begin
                st_d.acc_cs[CS_START_POS] = 1'b0; // [RQ17]
                st_d.acc_cs[CS_ERR_POS]   = 1'b1;
                ev[IRQ_ERR]               = 1'b1;
            end else begin
                st_d.rdy_cnt  = RDY_LOAD; // [RQ15]
                st_d.cur_addr = st_q.cur_addr + step_of(st_q.acc_cs[CS_SZ_LSB +: 3]); // [RQ16]
                st_d.left     = st_q.left - CNT_W'(1);
                ev[IRQ_DONE]  = 1'b1;
                if (st_q.bus_we) begin
                    st_d.acc_cs[CS_DV_POS] = 1'b0;
                end else begin
                    st_d.acc_cs[CS_DV_POS] = 1'b1; // [RQ10]
                    st_d.acc_data          = sb_rdata_i;
                end
                if (st_q.left == CNT_W'(1)) begin
                    st_d.acc_cs[CS_START_POS] = 1'b0;
                end
            end
        end

        // Test data out changes on the falling edge
        if (tck_fall) begin
            st_d.tdo    = st_q.sh[0];
            st_d.tdo_oe = (tap == TAP_SHDR);
        end
        if (!st_q.port_en) begin
            st_d.tdo_oe = 1'b0;
        end

        // Wishbone slave
        if (wb_req) begin
            st_d.wb_ack = 1'b1;
            st_d.wb_dat = '0;
            if (wb_we_i) begin
                if (wb_adr_i == WB_IRQ_CLR && wb_sel_i[0]) begin
                    st_d.irq_sts = st_q.irq_sts & ~wb_dat_i[IRQ_W-1:0];
                end else if (wb_adr_i == WB_IRQ_EN && wb_sel_i[0]) begin
                    st_d.irq_en = wb_dat_i[IRQ_W-1:0];
                end else if (wb_adr_i == WB_CTRL && wb_sel_i[0]) begin
                    st_d.port_en = wb_dat_i[0];
                end
            end else begin
                unique case (wb_adr_i)
                    WB_IRQ_STS: st_d.wb_dat = {29'h0, st_q.irq_sts};
                    WB_IRQ_EN:  st_d.wb_dat = {29'h0, st_q.irq_en};
                    WB_CTRL:    st_d.wb_dat = {31'h0, st_q.port_en};
                    WB_STATE:   st_d.wb_dat = {12'h0, st_q.mode, st_q.bus == BUS_ACT, 3'h0, st_q.left};
                    default:    st_d.wb_dat = '0;
                endcase
            end
        end

        // Events set after the clear so a same-cycle event survives
        st_d.irq_sts = st_d.irq_sts | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q         <= '0;
            st_q.mode    <= MODE_CMD;
            st_q.bus     <= BUS_IDLE;
            st_q.port_en <= CTRL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign tdo_o      = st_q.tdo;
    assign tdo_oe_o   = st_q.tdo_oe;
    assign rdy_n_o    = (st_q.rdy_cnt == '0);
    assign sb_req_o   = (st_q.bus == BUS_ACT);
    assign sb_we_o    = st_q.bus_we;
    assign sb_addr_o  = st_q.cur_addr;
    assign sb_wdata_o = st_q.acc_data;
    assign sb_size_o  = st_q.acc_cs[CS_SZ_LSB +: 2];
    assign wb_dat_o   = st_q.wb_dat;
    assign wb_ack_o   = st_q.wb_ack;
    assign irq_o      = |(st_q.irq_sts & st_q.irq_en);
endmodule : jdr_access

/* File: hw/jdr_pkg.sv */
// Shared constants and types for the debug register access block
package jdr_pkg;

    // Clock and ready pulse timing
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned RDY_LOW_NS    = 100;
    localparam int unsigned RDY_LOW_CYC   = (RDY_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Scan geometry
    localparam int unsigned CMD_BITS  = 7;
    localparam int unsigned DATA_BITS = 32;

    // Debug register indices
    localparam logic [5:0] IDX_ACC_CS   = 6'h07;
    localparam logic [5:0] IDX_ACC_ADDR = 6'h09;
    localparam logic [5:0] IDX_ACC_DATA = 6'h0a;

    // Access control/status layout
    localparam int unsigned CS_START_POS = 31;
    localparam int unsigned CS_MAP_LSB   = 28;
    localparam int unsigned CS_PRI_LSB   = 26;
    localparam int unsigned CS_RW_POS    = 25;
    localparam int unsigned CS_SZ_LSB    = 22;
    localparam int unsigned CS_CNT_LSB   = 8;
    localparam int unsigned CNT_W        = 14;
    localparam int unsigned CS_ERR_POS   = 1;
    localparam int unsigned CS_DV_POS    = 0;
    localparam logic [31:0] CS_WR_MASK   = 32'hffff_ff00;

    // System bus response code for an error
    localparam logic [1:0] SB_RESP_ERR = 2'b01;

    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] WB_IRQ_STS  = 8'h00;
    localparam logic [7:0] WB_IRQ_CLR  = 8'h04;
    localparam logic [7:0] WB_IRQ_EN   = 8'h08;
    localparam logic [7:0] WB_CTRL     = 8'h0c;
    localparam logic [7:0] WB_STATE    = 8'h10;
    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_DONE   = 0;
    localparam int unsigned IRQ_ERR    = 1;
    localparam int unsigned IRQ_CMD    = 2;
    localparam logic        CTRL_RST   = 1'b1;

    typedef enum logic [15:0] {
        TAP_TLR   = 16'h0001,
        TAP_RTI   = 16'h0002,
        TAP_SELDR = 16'h0004,
        TAP_CAPDR = 16'h0008,
        TAP_SHDR  = 16'h0010,
        TAP_EX1DR = 16'h0020,
        TAP_PSDR  = 16'h0040,
        TAP_EX2DR = 16'h0080,
        TAP_UPDR  = 16'h0100,
        TAP_SELIR = 16'h0200,
        TAP_CAPIR = 16'h0400,
        TAP_SHIR  = 16'h0800,
        TAP_EX1IR = 16'h1000,
        TAP_PSIR  = 16'h2000,
        TAP_EX2IR = 16'h4000,
        TAP_UPIR  = 16'h8000
    } jdr_tap_t;

    typedef enum logic [1:0] {
        MODE_CMD  = 2'b01,
        MODE_DATA = 2'b10
    } jdr_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACT  = 2'b10
    } jdr_bus_t;

endpackage : jdr_pkg

/* File: hw/jdr_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module jdr_sync
    import jdr_pkg::*;
#(
    parameter int unsigned W = 3
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } jdr_sync_st_t;

    jdr_sync_st_t st_q;
    jdr_sync_st_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule : jdr_sync

/* File: hw/jdr_tap.sv */
// Test access port controller, advanced on each test clock rising edge unless hold_i forces it to Test-Logic-Reset
`timescale 1ns/1ps
module jdr_tap
    import jdr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic hold_i,
    input  wire logic tck_rise_i,
    input  wire logic tms_i,
    output jdr_tap_t  state_o
);
    typedef struct packed {
        jdr_tap_t tap;
    } jdr_tap_st_t;

    jdr_tap_st_t st_q;
    jdr_tap_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (hold_i) begin
            st_d.tap = TAP_TLR;
        end else if (tck_rise_i) begin
            unique case (st_q.tap)
                TAP_TLR:   st_d.tap = tms_i ? TAP_TLR   : TAP_RTI;
                TAP_RTI:   st_d.tap = tms_i ? TAP_SELDR : TAP_RTI;
                TAP_SELDR: st_d.tap = tms_i ? TAP_SELIR : TAP_CAPDR;
                TAP_CAPDR: st_d.tap = tms_i ? TAP_EX1DR : TAP_SHDR;
                TAP_SHDR:  st_d.tap = tms_i ? TAP_EX1DR : TAP_SHDR;
                TAP_EX1DR: st_d.tap = tms_i ? TAP_UPDR  : TAP_PSDR;
                TAP_PSDR:  st_d.tap = tms_i ? TAP_EX2DR : TAP_PSDR;
                TAP_EX2DR: st_d.tap = tms_i ? TAP_UPDR  : TAP_SHDR;
                TAP_UPDR:  st_d.tap = tms_i ? TAP_SELDR : TAP_RTI;
                TAP_SELIR: st_d.tap = tms_i ? TAP_TLR   : TAP_CAPIR;
                TAP_CAPIR: st_d.tap = tms_i ? TAP_EX1IR : TAP_SHIR;
                TAP_SHIR:  st_d.tap = tms_i ? TAP_EX1IR : TAP_SHIR;
                TAP_EX1IR: st_d.tap = tms_i ? TAP_UPIR  : TAP_PSIR;
                TAP_PSIR:  st_d.tap = tms_i ? TAP_EX2IR : TAP_PSIR;
                TAP_EX2IR: st_d.tap = tms_i ? TAP_UPIR  : TAP_SHIR;
                TAP_UPIR:  st_d.tap = tms_i ? TAP_SELDR : TAP_RTI;
                default:   st_d.tap = TAP_TLR;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q.tap <= TAP_TLR;
        end else begin
            st_q <= st_d;
        end
    end

    assign state_o = st_q.tap;
endmodule : jdr_tap
